// [common/bfh_regs.vh]
// constants of the buck fault and hiccup supervisor
`ifndef BFH_REGS_VH
`define BFH_REGS_VH
// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define BFH_CLK_KHZ        50000
`define BFH_OV_TIME_NS     5000
`define BFH_UV_TIME_NS     20000
`define BFH_BLANK_TIME_NS  150
`define BFH_OV_CYC         ((`BFH_OV_TIME_NS * `BFH_CLK_KHZ + 999999) / 1000000)
`define BFH_UV_CYC         ((`BFH_UV_TIME_NS * `BFH_CLK_KHZ + 999999) / 1000000)
`define BFH_BLANK_CYC      ((`BFH_BLANK_TIME_NS * `BFH_CLK_KHZ + 999999) / 1000000)
`define BFH_HICCUP_PERIODS 4
`define BFH_OC_EVENTS      3
`define BFH_OC_WINDOW      8
// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define BFH_CTRL_OFS       4'h0
`define BFH_STATUS_OFS     4'h4
`define BFH_FLOG_OFS       4'h8
// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define BFH_CTRL_EN_BIT    0
`define BFH_CTRL_RST       1'b1
`define BFH_FLT_OV_BIT     0
`define BFH_FLT_UV_BIT     1
`define BFH_FLT_OC_BIT     2
`define BFH_FLT_TSD_BIT    3
`define BFH_ST_STATE_LSB   4
`define BFH_ST_REGOK_BIT   8
// ----------------------------------------------------------------
// states
// ----------------------------------------------------------------
`define BFH_S_OFF          3'h0
`define BFH_S_SOFT         3'h1
`define BFH_S_RUN          3'h2
`define BFH_S_OVDIS        3'h3
`define BFH_S_HICCUP       3'h4
`endif

// [core/bfh_supervisor.v]
// fault supervisor with hiccup restart for a synchronous buck stage
//
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "bfh_regs.vh"
// Operation
// - entering hiccup turns both switches off and pulls regulation-ok low
// - hiccup lasts four soft-start periods, then a new soft-start begins
// - in soft-start after hiccup only overcurrent detection is armed
// - overvoltage held over 5 us sets its fault and pulls regulation-ok low
// - overvoltage fault keeps high-side off and low-side on to discharge
// - after overvoltage, hiccup starts once undervoltage comparator asserts
// - undervoltage held over 20 us sets its fault and enters hiccup
// - undervoltage detection is off during any soft-start
// - low-side trip inhibits high-side; released next switching cycle after clear
// - three overcurrent events within eight switching cycles enter hiccup
// - low-side trip ignored for 150 ns after low-side turn-on
// - high-side trip ends the current high-side pulse at once
// - over-temperature turns switches off, pulls regulation-ok low, enters hiccup
// - after thermal shutdown, soft-start begins once over-temperature clears
// - regulation-ok released when fault-free and output within thresholds
// - regulation-ok pulled low on any fault or during soft-start
// - overcurrent is the only detection in every soft-start
// - soft-start begins only with enable high and both lockouts clear
module bfh_supervisor #(
  parameter OV_CYC    = `BFH_OV_CYC,
  parameter UV_CYC    = `BFH_UV_CYC,
  parameter BLANK_CYC = `BFH_BLANK_CYC,
  parameter OC_EVENTS = `BFH_OC_EVENTS
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  // comparator pins, asynchronous
  input  wire        ovCmp,
  input  wire        uvCmp,
  input  wire        lsOcCmp,
  input  wire        hsOcCmp,
  input  wire        otInd,
  input  wire        enCmp,
  input  wire        vinUvlo,
  input  wire        vddUvlo,
  // modulator and soft-start controller, same clock
  input  wire        pwmHigh,
  input  wire        swCycleStb,
  input  wire        ssDoneStb,
  input  wire        ssPeriodStb,
  // power stage and soft-start control
  output reg         hsGateEn_r,
  output reg         lsGateEn_r,
  output reg         ssStart_r,
  // open-drain regulation-ok pin
  output reg         regOkOut_r,
  output reg         regOkOe_n_r,
  // avalon-mm slave
  input  wire [3:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  output reg  [31:0] readdata,
  output reg         waitrequest
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam NPIN = 8;
  wire [NPIN-1:0] pinRaw;
  reg  [NPIN-1:0] pinS1_r;
  reg  [NPIN-1:0] pinS2_r;
  reg  [NPIN-1:0] pinS3_r;
  reg  [NPIN-1:0] pinQ_r;
  assign pinRaw = {vddUvlo, vinUvlo, enCmp, otInd, hsOcCmp, lsOcCmp, uvCmp, ovCmp};
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1) begin : gSync
      // a level counts only once the last two stages agree
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          pinS1_r[gi] <= 1'b0;
          pinS2_r[gi] <= 1'b0;
          pinS3_r[gi] <= 1'b0;
          pinQ_r[gi]  <= 1'b0;
        end else if (ce) begin
          pinS1_r[gi] <= pinRaw[gi];
          pinS2_r[gi] <= pinS1_r[gi];
          pinS3_r[gi] <= pinS2_r[gi];
          if (pinS2_r[gi] == pinS3_r[gi]) begin
            pinQ_r[gi] <= pinS3_r[gi];
          end
        end
      end
    end
  endgenerate
  wire ovS  = pinQ_r[0];
  wire uvS  = pinQ_r[1];
  wire lsOc = pinQ_r[2];
  wire hsOc = pinQ_r[3];
  wire otS  = pinQ_r[4];
  wire enS  = pinQ_r[5];
  wire vinL = pinQ_r[6];
  wire vddL = pinQ_r[7];

  // ----------------------------------------------------------------
  // state and registers
  // ----------------------------------------------------------------
  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg  [9:0]  ovCnt_r;
  reg  [9:0]  uvCnt_r;
  reg  [3:0]  blankCnt_r;
  reg  [2:0]  hicCnt_r;
  reg  [6:0]  ocHist_r;
  reg         ocThisCyc_r;
  reg         lsInhibit_r;
  reg         hsTerm_r;
  reg  [3:0]  fault_r;
  reg  [3:0]  faultLog_r;
  reg         ctrlEn_r;

  wire enReady  = enS & ~vinL & ~vddL & ctrlEn_r;
  wire active   = (state_r == `BFH_S_SOFT) || (state_r == `BFH_S_RUN);
  // qualified voltage and thermal detections are armed only in regulation; overvoltage discharge still acts on otS and uvS
  wire vArmed   = (state_r == `BFH_S_RUN);
  wire ovQual   = vArmed & ovS & (ovCnt_r == OV_CYC[9:0]);
  wire uvQual   = vArmed & uvS & (uvCnt_r == UV_CYC[9:0]);
  wire tsdHit   = vArmed & otS;
  wire lsTrip   = active & lsOc & (blankCnt_r == 4'h0);
  wire hsTrip   = active & hsOc & hsGateEn_r;
  wire ocEvent  = lsTrip | hsTrip;
  wire ocLimit  = active & (ones(ocHist_r[6:0]) + {3'h0, (ocThisCyc_r | ocEvent)}
                  >= OC_EVENTS[3:0]);
  wire hicDone  = (hicCnt_r == `BFH_HICCUP_PERIODS);

  // population count over the switching-cycle history
  function [3:0] ones;
    input [6:0] v;
    integer k;
    begin
      ones = 4'h0;
      for (k = 0; k < 7; k = k + 1) begin
        ones = ones + {3'h0, v[k]};
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      `BFH_S_OFF: begin
        if (enReady) state_nxt = `BFH_S_SOFT;
      end
      `BFH_S_SOFT: begin
        if (!enReady) state_nxt = `BFH_S_OFF;
        else if (ocLimit) state_nxt = `BFH_S_HICCUP;
        else if (ssDoneStb) state_nxt = `BFH_S_RUN;
      end
      `BFH_S_RUN: begin
        if (!enReady) state_nxt = `BFH_S_OFF;
        else if (tsdHit || uvQual || ocLimit) state_nxt = `BFH_S_HICCUP;
        else if (ovQual) state_nxt = `BFH_S_OVDIS;
      end
      `BFH_S_OVDIS: begin
        if (otS || uvS) state_nxt = `BFH_S_HICCUP;
      end
      `BFH_S_HICCUP: begin
        // restart waits for the delay and for the die to cool
        if (hicDone && !otS && enReady) state_nxt = `BFH_S_SOFT;
      end
      default: state_nxt = `BFH_S_OFF;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r     <= `BFH_S_OFF;
      ssStart_r   <= 1'b0;
      hicCnt_r    <= 3'h0;
      ovCnt_r     <= 10'h000;
      uvCnt_r     <= 10'h000;
      fault_r     <= 4'h0;
    end else if (ce) begin
      state_r   <= state_nxt;
      ssStart_r <= (state_nxt == `BFH_S_SOFT) && (state_r != `BFH_S_SOFT);
      if (state_r != `BFH_S_HICCUP) begin
        hicCnt_r <= 3'h0;
      end else if (ssPeriodStb && !hicDone) begin
        hicCnt_r <= hicCnt_r + 3'h1;
      end
      // qualification timers restart whenever the comparator drops
      if (!vArmed || !ovS) ovCnt_r <= 10'h000;
      else if (ovCnt_r != OV_CYC[9:0]) ovCnt_r <= ovCnt_r + 10'h001;
      if (!vArmed || !uvS) uvCnt_r <= 10'h000;
      else if (uvCnt_r != UV_CYC[9:0]) uvCnt_r <= uvCnt_r + 10'h001;
      if (state_nxt == `BFH_S_SOFT && state_r != `BFH_S_SOFT) begin
        fault_r <= 4'h0;
      end else begin
        if (ovQual) fault_r[`BFH_FLT_OV_BIT] <= 1'b1;
        if (uvQual) fault_r[`BFH_FLT_UV_BIT] <= 1'b1;
        if (ocLimit) fault_r[`BFH_FLT_OC_BIT] <= 1'b1;
        if (tsdHit || (state_r == `BFH_S_OVDIS && otS)) fault_r[`BFH_FLT_TSD_BIT] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // overcurrent handling and gate drive
  // ----------------------------------------------------------------
  reg hsNxt;
  reg lsNxt;
  always @* begin
    hsNxt = 1'b0;
    lsNxt = 1'b0;
    if (state_nxt == `BFH_S_OVDIS) begin
      lsNxt = 1'b1;
    end else if (active && state_nxt != `BFH_S_HICCUP && state_nxt != `BFH_S_OFF) begin
      hsNxt = pwmHigh & ~lsInhibit_r & ~lsTrip & ~hsTerm_r & ~hsTrip;
      lsNxt = ~hsNxt & ~pwmHigh;
    end
    // hiccup and off leave both drives low
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hsGateEn_r  <= 1'b0;
      lsGateEn_r  <= 1'b0;
      blankCnt_r  <= 4'h0;
      lsInhibit_r <= 1'b0;
      hsTerm_r    <= 1'b0;
      ocHist_r    <= 7'h00;
      ocThisCyc_r <= 1'b0;
    end else if (ce) begin
      hsGateEn_r <= hsNxt;
      lsGateEn_r <= lsNxt;
      if (lsNxt && !lsGateEn_r) blankCnt_r <= BLANK_CYC[3:0];
      else if (blankCnt_r != 4'h0) blankCnt_r <= blankCnt_r - 4'h1;
      if (lsTrip) lsInhibit_r <= 1'b1;
      else if (swCycleStb && !lsOc) lsInhibit_r <= 1'b0;
      // a terminated pulse stays off until the modulator ends it
      if (hsTrip) hsTerm_r <= 1'b1;
      else if (!pwmHigh) hsTerm_r <= 1'b0;
      if (!active) begin
        ocHist_r    <= 7'h00;
        ocThisCyc_r <= 1'b0;
      end else if (swCycleStb) begin
        ocHist_r    <= {ocHist_r[5:0], ocThisCyc_r | ocEvent};
        ocThisCyc_r <= 1'b0;
      end else if (ocEvent) begin
        ocThisCyc_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // regulation-ok open-drain output
  // ----------------------------------------------------------------
  wire regGood = (state_nxt == `BFH_S_RUN) && (fault_r == 4'h0) && !ovS && !uvS;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      regOkOut_r  <= 1'b0;
      regOkOe_n_r <= 1'b0;
    end else if (ce) begin
      regOkOut_r  <= 1'b0;
      regOkOe_n_r <= regGood;
    end
  end

  // ----------------------------------------------------------------
  // avalon-mm register slave
  // ----------------------------------------------------------------
  wire        acc   = (read | write) & waitrequest;
  wire        wrNow = write & ~waitrequest;
  wire [31:0] stWord = {23'h0, ~regOkOe_n_r, 1'b0, state_r, fault_r};
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0;
      ctrlEn_r    <= `BFH_CTRL_RST;
      faultLog_r  <= 4'h0;
    end else if (ce) begin
      // one wait cycle, then the answer; readdata stands at that edge
      waitrequest <= ~acc;
      if (acc && read) begin
        case (address)
          `BFH_CTRL_OFS:   readdata <= {31'h0, ctrlEn_r};
          `BFH_STATUS_OFS: readdata <= stWord;
          `BFH_FLOG_OFS:   readdata <= {28'h0, faultLog_r};
          default:         readdata <= 32'h0;
        endcase
      end
      if (wrNow && address == `BFH_CTRL_OFS) ctrlEn_r <= writedata[`BFH_CTRL_EN_BIT];
      // sticky log: a new fault wins over a clear in the same cycle
      if (wrNow && address == `BFH_FLOG_OFS) begin
        faultLog_r <= (faultLog_r & ~writedata[3:0]) | fault_r;
      end else begin
        faultLog_r <= faultLog_r | fault_r;
      end
    end
  end
endmodule // bfh_supervisor
`default_nettype wire

// [tb/bfh_supervisor_properties.sv]
// port assertions for the fault and hiccup supervisor
`timescale 1ns/1ps
`default_nettype none
module bfh_sup_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // comparators and modulator
  input wire logic ovCmp,
  input wire logic uvCmp,
  input wire logic lsOcCmp,
  input wire logic hsOcCmp,
  input wire logic otInd,
  input wire logic enCmp,
  input wire logic pwmHigh,
  // gates, soft-start and regulation-ok
  input wire logic hsGateEn_r,
  input wire logic lsGateEn_r,
  input wire logic ssStart_r,
  input wire logic regOkOut_r,
  input wire logic regOkOe_n_r,
  // register bus
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // a shoot-through would short the input rail
  chk_no_overlap: assert property (!(hsGateEn_r && lsGateEn_r))
    else $error("both gates enabled");
  chk_hot_low: assert property (otInd [*6] |-> !regOkOe_n_r)
    else $error("regulation-ok released while hot");
  chk_over_low: assert property (ovCmp [*6] |-> !regOkOe_n_r)
    else $error("regulation-ok released above window");
  chk_under_low: assert property (uvCmp [*6] |-> !regOkOe_n_r)
    else $error("regulation-ok released below window");
  chk_start_enable: assert property ((!enCmp) [*8] |-> !ssStart_r)
    else $error("soft-start without enable");
  chk_start_pulse: assert property (ssStart_r |=> !ssStart_r && !regOkOe_n_r)
    else $error("soft-start pulse too long or pin released");
  chk_ls_inhibit: assert property (lsOcCmp [*8] |-> !$rose(hsGateEn_r))
    else $error("high-side turned on during low-side trip");
  chk_hs_kill: assert property
    ($rose(hsOcCmp) && pwmHigh ##1 (hsOcCmp && pwmHigh) [*7] |-> !hsGateEn_r)
    else $error("high-side pulse not ended on trip");
  chk_od_never_high: assert property (regOkOut_r == 1'b0)
    else $error("open-drain pin driven high");
  chk_bus_answer: assert property ((read || write) && waitrequest && ce |=> !waitrequest)
    else $error("bus request not answered");
endmodule // bfh_sup_props
`default_nettype wire

// [tb/bfh_pwm_model.sv]
// modulator model: fixed switching cycle with a high-side request window
`timescale 1ns/1ps
`default_nettype none
module bfh_pwm_model #(
  parameter PERIOD = 20,
  parameter ON     = 10
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // modulator outputs
  output var  logic pwmHigh,
  output var  logic swCycleStb
);
  logic [7:0] cnt_r;
  // long on-window so a trip can be held inside one pulse
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r      <= 8'h00;
      pwmHigh    <= 1'b0;
      swCycleStb <= 1'b0;
    end else begin
      cnt_r      <= (cnt_r == PERIOD - 1) ? 8'h00 : cnt_r + 8'h01;
      swCycleStb <= (cnt_r == 8'h00);
      pwmHigh    <= (cnt_r < ON);
    end
  end
endmodule // bfh_pwm_model
`default_nettype wire

// [tb/test_bfh_supervisor.sv]
// self-checking bench for the fault and hiccup supervisor
`timescale 1ns/1ps
`default_nettype none
`include "bfh_regs.vh"
module test_bfh_supervisor;
  logic        clk = 1'b0, rst = 1'b1, enCmp = 1'b0, vinUvlo = 1'b1, vddUvlo = 1'b1;
  logic        ovCmp = 1'b0, uvCmp = 1'b0, lsOcCmp = 1'b0, hsOcCmp = 1'b0, otInd = 1'b0;
  logic        ssDoneStb = 1'b0, ssPeriodStb = 1'b0, read = 1'b0, write = 1'b0;
  logic [3:0]  address = 4'h0;
  logic [31:0] writedata = 32'h0, rd;
  wire logic   pwmHigh, swCycleStb, hsGateEn_r, lsGateEn_r, ssStart_r, regOkOut_r;
  wire logic   regOkOe_n_r, waitrequest;
  wire logic [31:0] readdata;
  int          failures = 0, n_checks = 0, nStart = 0;
  always #10 clk = ~clk;
  always @(posedge clk) if (ssStart_r === 1'b1) nStart <= nStart + 1;
  bfh_pwm_model pwm_u (.clk(clk), .rst(rst), .pwmHigh(pwmHigh), .swCycleStb(swCycleStb));
  // shortened timers keep the run brief
  bfh_supervisor #(.OV_CYC(10), .UV_CYC(20), .BLANK_CYC(3)) dut_u (
    .clk(clk), .rst(rst), .ce(1'b1), .ovCmp(ovCmp), .uvCmp(uvCmp), .lsOcCmp(lsOcCmp),
    .hsOcCmp(hsOcCmp), .otInd(otInd), .enCmp(enCmp), .vinUvlo(vinUvlo), .vddUvlo(vddUvlo),
    .pwmHigh(pwmHigh), .swCycleStb(swCycleStb), .ssDoneStb(ssDoneStb),
    .ssPeriodStb(ssPeriodStb), .hsGateEn_r(hsGateEn_r), .lsGateEn_r(lsGateEn_r),
    .ssStart_r(ssStart_r), .regOkOut_r(regOkOut_r), .regOkOe_n_r(regOkOe_n_r),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest));
  task chk(input [31:0] got, input [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task acc(input bit wr, input [3:0] a, input [31:0] d);
    @(posedge clk);
    address   <= a;
    writedata <= d;
    read      <= !wr;
    write     <= wr;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask
  task waitSt(input [2:0] s);
    for (int i = 0; i < 60; i++) begin
      acc(1'b0, `BFH_STATUS_OFS, 32'h0);
      if (rd[6:4] === s) break;
    end
  endtask
  task stb(input bit per, input int n);
    repeat (n) begin
      @(posedge clk);
      ssPeriodStb <= per;
      ssDoneStb   <= !per;
      @(posedge clk);
      ssPeriodStb <= 1'b0;
      ssDoneStb   <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  task hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  task restart;
    int k;
    k = nStart;
    stb(1'b1, 3);
    chk(nStart, k);
    stb(1'b1, 1);
    chk(nStart, k + 1);
    waitSt(`BFH_S_SOFT);
    // the ramp after a hiccup ignores every fault but overcurrent
    {ovCmp, uvCmp, otInd} <= 3'h7;
    hold(30);
    acc(1'b0, `BFH_STATUS_OFS, 32'h0);
    chk(rd[6:0], {`BFH_S_SOFT, 4'h0});
    {ovCmp, uvCmp, otInd} <= 3'h0;
    hold(8);
    stb(1'b0, 1);
    waitSt(`BFH_S_RUN);
  endtask
  // one high-side trip held across most of a pulse
  task hsPulse;
    @(posedge pwmHigh);
    @(posedge clk);
    hsOcCmp <= 1'b1;
    hold(8);
    chk(hsGateEn_r, 1'b0);
    hold(4);
    hsOcCmp <= 1'b0;
  endtask
  task results;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    results;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    hold(1);
    chk({hsGateEn_r, lsGateEn_r, regOkOe_n_r, waitrequest}, 4'h1);
    acc(1'b0, `BFH_CTRL_OFS, 32'h0);
    chk(rd, 32'h1);
    acc(1'b1, `BFH_CTRL_OFS, 32'h0);
    acc(1'b0, `BFH_CTRL_OFS, 32'h0);
    chk(rd, 32'h0);
    acc(1'b0, 4'hC, 32'h0);
    chk(rd, 32'h0);
    acc(1'b1, `BFH_CTRL_OFS, 32'h1);
    enCmp <= 1'b1;
    hold(20);
    chk(nStart, 0);
    // vddUvlo alone must still hold the ramp back
    vinUvlo <= 1'b0;
    hold(20);
    chk(nStart, 0);
    vddUvlo <= 1'b0;
    waitSt(`BFH_S_SOFT);
    chk(nStart, 1);
    // every fault but overcurrent must be ignored while ramping
    {ovCmp, uvCmp, otInd} <= 3'h7;
    hold(40);
    acc(1'b0, `BFH_STATUS_OFS, 32'h0);
    chk(rd[6:0], {`BFH_S_SOFT, 4'h0});
    {ovCmp, uvCmp, otInd} <= 3'h0;
    hold(8);
    chk(regOkOe_n_r, 1'b0);
    stb(1'b0, 1);
    waitSt(`BFH_S_RUN);
    hold(8);
    chk(regOkOe_n_r, 1'b1);
    $display("test start done");
    ovCmp <= 1'b1;
    waitSt(`BFH_S_OVDIS);
    chk(rd[6:4], `BFH_S_OVDIS);
    hold(2);
    chk({hsGateEn_r, lsGateEn_r, regOkOe_n_r}, 3'h2);
    ovCmp <= 1'b0;
    hold(30);
    acc(1'b0, `BFH_STATUS_OFS, 32'h0);
    chk(rd[6:4], `BFH_S_OVDIS);
    uvCmp <= 1'b1;
    waitSt(`BFH_S_HICCUP);
    chk(rd[6:4], `BFH_S_HICCUP);
    chk({hsGateEn_r, lsGateEn_r, regOkOe_n_r}, 3'h0);
    uvCmp <= 1'b0;
    restart;
    // the log keeps the overvoltage after restart until software clears it
    acc(1'b0, `BFH_FLOG_OFS, 32'h0);
    chk(rd, 32'h1);
    acc(1'b1, `BFH_FLOG_OFS, 32'h1);
    acc(1'b0, `BFH_FLOG_OFS, 32'h0);
    chk(rd, 32'h0);
    $display("test overvoltage done");
    otInd <= 1'b1;
    waitSt(`BFH_S_HICCUP);
    chk(rd[6:4], `BFH_S_HICCUP);
    chk({hsGateEn_r, lsGateEn_r, regOkOe_n_r}, 3'h0);
    stb(1'b1, 5);
    chk(nStart, 2);
    otInd <= 1'b0;
    hold(12);
    chk(nStart, 3);
    waitSt(`BFH_S_SOFT);
    stb(1'b0, 1);
    waitSt(`BFH_S_RUN);
    repeat (2) begin
      uvCmp <= 1'b1;
      hold(15);
      uvCmp <= 1'b0;
      hold(10);
    end
    acc(1'b0, `BFH_STATUS_OFS, 32'h0);
    chk(rd[6:4], `BFH_S_RUN);
    uvCmp <= 1'b1;
    waitSt(`BFH_S_HICCUP);
    chk(rd[6:4], `BFH_S_HICCUP);
    uvCmp <= 1'b0;
    restart;
    $display("test thermal and undervoltage done");
    // two trips in neighbouring cycles stay below the limit, a third trips it
    hsPulse;
    hsPulse;
    hold(30);
    acc(1'b0, `BFH_STATUS_OFS, 32'h0);
    chk(rd[6:4], `BFH_S_RUN);
    hsPulse;
    waitSt(`BFH_S_HICCUP);
    chk(rd[6:4], `BFH_S_HICCUP);
    restart;
    lsOcCmp <= 1'b1;
    hold(6);
    @(posedge pwmHigh);
    hold(3);
    chk(hsGateEn_r, 1'b0);
    waitSt(`BFH_S_HICCUP);
    chk(rd[6:4], `BFH_S_HICCUP);
    lsOcCmp <= 1'b0;
    restart;
    $display("test overcurrent done");
    results;
  end
endmodule // test_bfh_supervisor
bind bfh_supervisor bfh_sup_props chk_u (.clk(clk), .rst(rst), .ce(ce), .ovCmp(ovCmp),
  .uvCmp(uvCmp), .lsOcCmp(lsOcCmp), .hsOcCmp(hsOcCmp), .otInd(otInd), .enCmp(enCmp),
  .pwmHigh(pwmHigh), .hsGateEn_r(hsGateEn_r), .lsGateEn_r(lsGateEn_r),
  .ssStart_r(ssStart_r), .regOkOut_r(regOkOut_r), .regOkOe_n_r(regOkOe_n_r),
  .read(read), .write(write), .waitrequest(waitrequest));
`default_nettype wire
